// >>> uss_fifo.sv
// byte fifo with single-entry overwrite mode, used for receive and transmit
module uss_fifo
    import uss_pkg::*;
(
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_n,
    input  wire logic                  i_clr,
    input  wire logic                  i_single,
    input  wire logic                  i_push,
    input  wire logic [7:0]            i_data,
    input  wire logic                  i_pop,
    output logic      [7:0]            o_head,
    output logic      [uss_pkg::USS_CW-1:0] o_count,
    output logic                       o_empty,
    output logic                       o_lost
);
    import uss_pkg::*;

    logic [7:0]        mem_r [USS_DEPTH];
    logic [USS_PW-1:0] wr_ptr_r;
    logic [USS_PW-1:0] rd_ptr_r;
    logic [USS_CW-1:0] count_r;
    logic              full;
    logic              do_pop;
    logic              do_push;
    logic              ovw;

    // ************************************************************
    // occupancy decode
    // ************************************************************
    assign o_empty = (count_r == '0);
    assign full    = i_single ? !o_empty : (count_r == USS_DEPTH_CNT);
    assign do_pop  = i_pop && !o_empty;
    assign do_push = i_push && (!full || do_pop);
    assign ovw     = i_push && full && !do_pop && i_single;
    assign o_lost  = i_push && full && !do_pop;
    assign o_head  = mem_r[rd_ptr_r];
    assign o_count = count_r;

    // storage: single mode replaces the pending byte when full
    always_ff @(posedge i_clk) begin
        if (do_push) begin
            mem_r[wr_ptr_r] <= i_data;
        end else if (ovw) begin
            mem_r[rd_ptr_r] <= i_data;
        end
    end

    // pointers and count
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else if (i_clr) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_r <= wr_ptr_r + 4'h1;
            end
            if (do_pop) begin
                rd_ptr_r <= rd_ptr_r + 4'h1;
            end
            if (do_push && !do_pop) begin
                count_r <= count_r + 5'h01;
            end else if (do_pop && !do_push) begin
                count_r <= count_r - 5'h01;
            end
        end
    end

endmodule : uss_fifo

// >>> uss_link_model.sv
// far-side model: serial and infrared deframers and the transmit framer
module uss_link_model (
    input  wire logic       i_clk,
    output logic            o_ser_valid,
    output logic [7:0]      o_ser_data,
    output logic            o_ir_valid,
    output logic [7:0]      o_ir_data,
    input  wire logic       i_tx_valid,
    input  wire logic [7:0] i_tx_data,
    output logic            o_tx_ready
);
    timeunit 1ns;
    timeprecision 100ps;

    bit         stall = 1'b0;
    logic [7:0] tx_got[$];

    // idle lines at time zero
    initial begin
        o_ser_valid = 1'b0;
        o_ser_data  = 8'h00;
        o_ir_valid  = 1'b0;
        o_ir_data   = 8'h00;
        o_tx_ready  = 1'b0;
    end

    // one byte as a one-cycle strobe; afterwards the data lines show the inverse
    task automatic send(input bit ir, input logic [7:0] d);
        if (ir) begin
            o_ir_valid <= 1'b1;
            o_ir_data  <= d;
        end else begin
            o_ser_valid <= 1'b1;
            o_ser_data  <= d;
        end
        @(posedge i_clk);
        o_ir_valid  <= 1'b0;
        o_ser_valid <= 1'b0;
        o_ir_data   <= ~o_ir_data;
        o_ser_data  <= ~o_ser_data;
        @(posedge i_clk);
    endtask : send

    // framer takes bytes, sometimes slowly, never while stalled
    always @(posedge i_clk) begin
        if (i_tx_valid && o_tx_ready) begin
            tx_got.push_back(i_tx_data);
        end
        o_tx_ready <= !stall && ($urandom_range(3, 0) != 0);
    end
endmodule : uss_link_model

// >>> uss_pkg.sv
// shared constants and decode helpers for the uart shadow data port
package uss_pkg;

    // ************************************************************
    // fifo geometry
    // ************************************************************
    localparam int          USS_DEPTH        = 16;
    localparam int          USS_PW           = 4;
    localparam int          USS_CW           = 5;
    localparam logic [4:0]  USS_DEPTH_CNT    = 5'h10;

    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam logic [31:0] USS_ALIAS_BASE   = 32'h5000_1130;
    localparam logic [31:0] USS_ALIAS_14     = 32'h5000_1168;
    localparam logic [31:0] USS_ALIAS_15     = 32'h5000_116c;
    localparam logic [31:0] USS_CTRL_ADDR    = 32'h5000_1180;
    localparam logic [31:0] USS_STAT_ADDR    = 32'h5000_1184;

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int          USS_CTRL_FIFO_EN = 0;
    localparam int          USS_CTRL_IR_MODE = 1;
    localparam int          USS_STAT_DR      = 0;
    localparam int          USS_STAT_OE      = 1;
    localparam int          USS_STAT_HE      = 5;
    localparam logic [1:0]  USS_CTRL_RST     = 2'h0;
    localparam logic [7:0]  USS_ALIAS_RST    = 8'h00;

    // ************************************************************
    // axi4-lite responses
    // ************************************************************
    localparam logic [1:0]  USS_RESP_OKAY    = 2'h0;
    localparam logic [1:0]  USS_RESP_SLVERR  = 2'h2;

    // true for any of the sixteen word-aligned alias locations
    function automatic logic uss_is_alias(input logic [31:0] addr);
        uss_is_alias = (addr >= USS_ALIAS_BASE) && (addr <= USS_ALIAS_15)
                       && (addr[1:0] == 2'h0);
    endfunction : uss_is_alias

endpackage : uss_pkg

// >>> uss_top.sv
// uart shadow data port: alias locations over axi4-lite with rx and tx byte paths
// ************************************************************
// Summary of operation
// RQ1: sixteen word aliases all reach the same receive and transmit path.
// RQ2: alias reads return the received byte in bits 7:0, serial or infrared.
// RQ3: read data is meaningful only while data-ready is set.
// RQ4: fifos off, a new byte overwrites an unread one and flags overrun.
// RQ5: fifos on, alias reads return the receive fifo head.
// RQ6: receive fifo full, new byte dropped, stored kept, overrun flagged.
// RQ7: alias writes feed the transmit path; infrared mode uses the infrared output.
// RQ8: software writes only while the holding-empty flag is set.
// RQ9: fifos off, one write clears the holding-empty flag.
// RQ10: fifos off, further writes replace the pending transmit byte.
// RQ11: fifos on, up to sixteen bytes accepted before full.
// RQ12: writes while the transmit fifo is full are discarded.
// RQ13: upper alias bytes read zero and ignore writes.
// ************************************************************
module uss_top
    import uss_pkg::*;
(
    input  wire logic        I_SYS_CLK,
    input  wire logic        I_RST_N,
    // axi4-lite slave
    input  wire logic [31:0] I_AWADDR,
    input  wire logic        I_AWVALID,
    output logic             O_AWREADY,
    input  wire logic [31:0] I_WDATA,
    input  wire logic [3:0]  I_WSTRB,
    input  wire logic        I_WVALID,
    output logic             O_WREADY,
    output logic [1:0]       O_BRESP,
    output logic             O_BVALID,
    input  wire logic        I_BREADY,
    input  wire logic [31:0] I_ARADDR,
    input  wire logic        I_ARVALID,
    output logic             O_ARREADY,
    output logic [31:0]      O_RDATA,
    output logic [1:0]       O_RRESP,
    output logic             O_RVALID,
    input  wire logic        I_RREADY,
    // received bytes from the serial and infrared deframers
    input  wire logic        I_SER_RX_VALID,
    input  wire logic [7:0]  I_SER_RX_DATA,
    input  wire logic        I_IR_RX_VALID,
    input  wire logic [7:0]  I_IR_RX_DATA,
    // transmit byte stream to the framer
    output logic             O_TX_VALID,
    output logic [7:0]       O_TX_DATA,
    input  wire logic        I_TX_READY,
    output logic             O_TX_IR_SEL,
    // status toward the line status logic
    output logic             O_DATA_READY,
    output logic             O_HOLDING_EMPTY,
    output logic             O_OVERRUN,
    output logic             O_FIFO_EN
);
    import uss_pkg::*;

    logic             aw_hold_r;
    logic [31:0]      awaddr_r;
    logic             w_hold_r;
    logic [7:0]       wdata_r;
    logic [1:0]       wctl_r;
    logic             wstrb0_r;
    logic             bvalid_r;
    logic [1:0]       bresp_r;
    logic             rvalid_r;
    logic [31:0]      rdata_r;
    logic [1:0]       rresp_r;
    logic [1:0]       ctrl_r;
    logic             oe_sticky_r;
    logic             overrun_r;
    logic             wr_go;
    logic             wr_alias;
    logic             wr_ctrl;
    logic             rd_go;
    logic             rd_alias;
    logic             rd_stat;
    logic             fifo_clr;
    logic             fifo_en;
    logic             ir_mode;
    logic             rx_push;
    logic [7:0]       rx_byte;
    logic [7:0]       rx_head;
    logic [USS_CW-1:0] rx_count;
    logic             rx_empty;
    logic             rx_lost;
    logic             tx_push;
    logic             tx_pop;
    logic [USS_CW-1:0] tx_count;
    logic             tx_empty;

    // ************************************************************
    // write channel handshakes
    // ************************************************************
    assign O_AWREADY = !aw_hold_r && !bvalid_r;
    assign O_WREADY  = !w_hold_r && !bvalid_r;
    assign wr_go     = aw_hold_r && w_hold_r && !bvalid_r;
    assign wr_alias  = wr_go && uss_is_alias(awaddr_r); // [RQ1]
    assign wr_ctrl   = wr_go && (awaddr_r == USS_CTRL_ADDR) && wstrb0_r;
    assign tx_push   = wr_alias && wstrb0_r; // [RQ7] [RQ13]
    assign O_BVALID  = bvalid_r;
    assign O_BRESP   = bresp_r;

    // address and data are caught independently, in either order
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            aw_hold_r <= 1'b0;
            awaddr_r  <= '0;
            w_hold_r  <= 1'b0;
            wdata_r   <= USS_ALIAS_RST;
            wctl_r    <= USS_CTRL_RST;
            wstrb0_r  <= 1'b0;
        end else begin
            if (I_AWVALID && O_AWREADY) begin
                aw_hold_r <= 1'b1;
                awaddr_r  <= I_AWADDR;
            end else if (wr_go) begin
                aw_hold_r <= 1'b0;
            end
            if (I_WVALID && O_WREADY) begin
                w_hold_r <= 1'b1;
                wdata_r  <= I_WDATA[7:0]; // upper bytes never stored [RQ13]
                wctl_r   <= I_WDATA[1:0];
                wstrb0_r <= I_WSTRB[0];
            end else if (wr_go) begin
                w_hold_r <= 1'b0;
            end
        end
    end

    // write response follows both halves
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            bvalid_r <= 1'b0;
            bresp_r  <= USS_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r  <= (uss_is_alias(awaddr_r) || awaddr_r == USS_CTRL_ADDR
                         || awaddr_r == USS_STAT_ADDR) ? USS_RESP_OKAY : USS_RESP_SLVERR;
        end else if (I_BREADY) begin
            bvalid_r <= 1'b0;
        end
    end

    // ************************************************************
    // control register: fifo enable and infrared mode
    // ************************************************************
    assign fifo_en     = ctrl_r[USS_CTRL_FIFO_EN];
    assign ir_mode     = ctrl_r[USS_CTRL_IR_MODE];
    assign fifo_clr    = wr_ctrl && (wctl_r[USS_CTRL_FIFO_EN] != fifo_en);
    assign O_FIFO_EN   = fifo_en;
    assign O_TX_IR_SEL = ir_mode; // framer drives active-low infrared output [RQ7]

    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            ctrl_r <= USS_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_r <= wctl_r;
        end
    end

    // ************************************************************
    // read channel
    // ************************************************************
    assign O_ARREADY = !rvalid_r;
    assign rd_go     = I_ARVALID && !rvalid_r;
    assign rd_alias  = rd_go && uss_is_alias(I_ARADDR); // [RQ1]
    assign rd_stat   = rd_go && (I_ARADDR == USS_STAT_ADDR);
    assign O_RVALID  = rvalid_r;
    assign O_RDATA   = rdata_r;
    assign O_RRESP   = rresp_r;

    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rvalid_r <= 1'b0;
            rdata_r  <= '0;
            rresp_r  <= USS_RESP_OKAY;
        end else if (rd_go) begin
            rvalid_r <= 1'b1;
            rresp_r  <= USS_RESP_OKAY;
            rdata_r  <= '0;
            if (uss_is_alias(I_ARADDR)) begin
                rdata_r[7:0] <= rx_head; // [RQ2] [RQ5] [RQ13]
            end else if (I_ARADDR == USS_CTRL_ADDR) begin
                rdata_r[1:0] <= ctrl_r;
            end else if (I_ARADDR == USS_STAT_ADDR) begin
                rdata_r[USS_STAT_DR] <= !rx_empty; // [RQ3]
                rdata_r[USS_STAT_OE] <= oe_sticky_r;
                rdata_r[USS_STAT_HE] <= tx_empty;
            end else begin
                rresp_r <= USS_RESP_SLVERR;
            end
        end else if (I_RREADY) begin
            rvalid_r <= 1'b0;
        end
    end

    // ************************************************************
    // receive path
    // ************************************************************
    assign rx_push      = ir_mode ? I_IR_RX_VALID : I_SER_RX_VALID; // [RQ2]
    assign rx_byte      = ir_mode ? I_IR_RX_DATA : I_SER_RX_DATA;
    assign O_DATA_READY = !rx_empty; // [RQ3]
    assign O_OVERRUN    = overrun_r;

    // single mode overwrites, fifo mode drops [RQ4] [RQ6]
    uss_fifo u_rx_fifo (
        .i_clk    (I_SYS_CLK),
        .i_rst_n  (I_RST_N),
        .i_clr    (fifo_clr),
        .i_single (!fifo_en),
        .i_push   (rx_push),
        .i_data   (rx_byte),
        .i_pop    (rd_alias),
        .o_head   (rx_head),
        .o_count  (rx_count),
        .o_empty  (rx_empty),
        .o_lost   (rx_lost)
    );

    // overrun pulse and sticky flag; a new overrun wins over the read clear
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            overrun_r   <= 1'b0;
            oe_sticky_r <= 1'b0;
        end else begin
            overrun_r <= rx_lost; // [RQ4] [RQ6]
            if (rx_lost) begin
                oe_sticky_r <= 1'b1;
            end else if (rd_stat) begin
                oe_sticky_r <= 1'b0;
            end
        end
    end

    // ************************************************************
    // transmit path
    // ************************************************************
    assign tx_pop          = O_TX_VALID && I_TX_READY;
    assign O_TX_VALID      = !tx_empty;
    assign O_HOLDING_EMPTY = tx_empty; // [RQ8] [RQ9]

    // single mode replaces pending byte [RQ10]; full fifo drops [RQ11] [RQ12]
    uss_fifo u_tx_fifo (
        .i_clk    (I_SYS_CLK),
        .i_rst_n  (I_RST_N),
        .i_clr    (fifo_clr),
        .i_single (!fifo_en),
        .i_push   (tx_push),
        .i_data   (wdata_r),
        .i_pop    (tx_pop),
        .o_head   (O_TX_DATA),
        .o_count  (tx_count),
        .o_empty  (tx_empty),
        .o_lost   ()
    );

    // ************************************************************
    // assertions
    // ************************************************************
    property p_alias_any;
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        (wr_go && wstrb0_r && awaddr_r >= USS_ALIAS_BASE && awaddr_r <= USS_ALIAS_15
         && awaddr_r[1:0] == 2'h0) |-> tx_push;
    endproperty
    a_alias_any: assert property (p_alias_any) else $error("alias write not taken"); // [RQ1]

    property p_rd_head;
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        (rd_alias && !fifo_clr) |=> (O_RDATA[7:0] == $past(rx_head)) && O_RVALID;
    endproperty
    a_rd_head: assert property (p_rd_head) else $error("alias read not head byte"); // [RQ5]

    property p_rd_upper;
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        rd_alias |=> (O_RDATA[31:8] == 24'h0);
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("alias upper byte not zero"); // [RQ13]

    property p_dr;
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        rx_push && !rd_alias && !fifo_clr |=> O_DATA_READY;
    endproperty
    a_dr: assert property (p_dr) else $error("data ready missing after receive"); // [RQ3]

    property p_rx_ovw;
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        (!fifo_en && !rx_empty && rx_push && !rd_alias && !fifo_clr)
        |=> O_OVERRUN && rx_head == $past(rx_byte) && rx_count == 5'h01;
    endproperty
    a_rx_ovw: assert property (p_rx_ovw) else $error("single mode overwrite wrong"); // [RQ4]

    property p_rx_drop;
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        (fifo_en && rx_count == USS_DEPTH_CNT && rx_push && !rd_alias && !fifo_clr)
        |=> O_OVERRUN && $stable(rx_head) && rx_count == USS_DEPTH_CNT;
    endproperty
    a_rx_drop: assert property (p_rx_drop) else $error("full rx fifo not kept"); // [RQ6]

    property p_he_clear;
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        (!fifo_en && tx_empty && tx_push && !fifo_clr) |=> !O_HOLDING_EMPTY ##0 O_TX_VALID;
    endproperty
    a_he_clear: assert property (p_he_clear) else $error("holding empty not cleared"); // [RQ9]

    property p_tx_replace;
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        (!fifo_en && !tx_empty && tx_push && !tx_pop && !fifo_clr)
        |=> O_TX_DATA == $past(wdata_r) && tx_count == 5'h01;
    endproperty
    a_tx_replace: assert property (p_tx_replace) else $error("pending byte not replaced"); // [RQ10]

    property p_tx_fill;
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        (fifo_en && tx_count < USS_DEPTH_CNT && tx_push && !tx_pop && !fifo_clr)
        |=> tx_count == $past(tx_count) + 5'h01;
    endproperty
    a_tx_fill: assert property (p_tx_fill) else $error("tx fifo did not accept"); // [RQ11]

    property p_tx_drop;
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        (fifo_en && tx_count == USS_DEPTH_CNT && tx_push && !tx_pop && !fifo_clr)
        |=> tx_count == USS_DEPTH_CNT ##0 $stable(O_TX_DATA);
    endproperty
    a_tx_drop: assert property (p_tx_drop) else $error("full tx fifo took a write"); // [RQ12]

    property p_ir_rx;
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        (ir_mode && I_IR_RX_VALID && rx_empty && !fifo_clr)
        |=> O_DATA_READY && rx_head == $past(I_IR_RX_DATA);
    endproperty
    a_ir_rx: assert property (p_ir_rx) else $error("infrared byte not received"); // [RQ2]

endmodule : uss_top

// >>> uss_top_tb.sv
// self-checking bench for the uart shadow data port
module uss_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import uss_pkg::*;

    logic        I_SYS_CLK, I_RST_N, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY;
    logic [31:0] I_AWADDR, I_WDATA, I_ARADDR, O_RDATA;
    logic [3:0]  I_WSTRB;
    logic        O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_TX_VALID, I_TX_READY;
    logic [1:0]  O_BRESP, O_RRESP;
    logic        I_SER_RX_VALID, I_IR_RX_VALID, O_TX_IR_SEL, O_DATA_READY, O_HOLDING_EMPTY;
    logic        O_OVERRUN, O_FIFO_EN;
    logic [7:0]  I_SER_RX_DATA, I_IR_RX_DATA, O_TX_DATA;
    logic [7:0]  rxm[$];
    logic [7:0]  txm[$];
    bit          fifo_on, ir_on;
    int          err_total, checked, lost, ovr_seen, i;
    logic [31:0] d;
    logic [1:0]  r;

    uss_top uut (.I_SYS_CLK, .I_RST_N, .I_AWADDR, .I_AWVALID, .O_AWREADY, .I_WDATA, .I_WSTRB,
        .I_WVALID, .O_WREADY, .O_BRESP, .O_BVALID, .I_BREADY, .I_ARADDR, .I_ARVALID, .O_ARREADY,
        .O_RDATA, .O_RRESP, .O_RVALID, .I_RREADY, .I_SER_RX_VALID, .I_SER_RX_DATA,
        .I_IR_RX_VALID, .I_IR_RX_DATA, .O_TX_VALID, .O_TX_DATA, .I_TX_READY, .O_TX_IR_SEL,
        .O_DATA_READY, .O_HOLDING_EMPTY, .O_OVERRUN, .O_FIFO_EN);

    uss_link_model link (.i_clk(I_SYS_CLK), .o_ser_valid(I_SER_RX_VALID),
        .o_ser_data(I_SER_RX_DATA), .o_ir_valid(I_IR_RX_VALID), .o_ir_data(I_IR_RX_DATA),
        .i_tx_valid(O_TX_VALID), .i_tx_data(O_TX_DATA), .o_tx_ready(I_TX_READY));

    // 250 MHz clock
    initial begin
        I_SYS_CLK = 1'b0;
        forever #2 I_SYS_CLK = ~I_SYS_CLK;
    end

    // count overrun pulses mid-cycle, clear of the edge that ends them
    always @(negedge I_SYS_CLK) begin
        if (O_OVERRUN === 1'b1) ovr_seen++;
    end

    // ************************************************************
    // report, compare and bus tasks
    // ************************************************************
    task automatic tally_and_finish();
        if (err_total == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish

    task automatic hang();
        err_total++;
        $display("FAIL %0t wait ran out", $time);
        tally_and_finish();
    endtask : hang

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_word

    // handshakes are sampled at the falling edge, acted on at the next rising edge
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] dw, output logic [1:0] rs);
        bit aw_hs, w_hs, done;
        int n;
        done = 1'b0;
        I_AWADDR  <= a;
        I_WDATA   <= dw;
        I_AWVALID <= 1'b1;
        I_WVALID  <= 1'b1;
        for (n = 0; n < 200 && !done; n++) begin
            @(negedge I_SYS_CLK);
            aw_hs = I_AWVALID && O_AWREADY;
            w_hs  = I_WVALID && O_WREADY;
            done  = (O_BVALID === 1'b1);
            rs    = O_BRESP;
            @(posedge I_SYS_CLK);
            if (aw_hs) I_AWVALID <= 1'b0;
            if (w_hs) I_WVALID <= 1'b0;
        end
        if (!done) hang();
    endtask : axi_wr

    task automatic axi_rd(input logic [31:0] a, output logic [31:0] dr, output logic [1:0] rs);
        bit ar_hs, done;
        int n;
        done = 1'b0;
        I_ARADDR  <= a;
        I_ARVALID <= 1'b1;
        for (n = 0; n < 200 && !done; n++) begin
            @(negedge I_SYS_CLK);
            ar_hs = I_ARVALID && O_ARREADY;
            done  = (O_RVALID === 1'b1);
            dr    = O_RDATA;
            rs    = O_RRESP;
            @(posedge I_SYS_CLK);
            if (ar_hs) I_ARVALID <= 1'b0;
        end
        if (!done) hang();
    endtask : axi_rd

    // ************************************************************
    // model-backed operations
    // ************************************************************
    task automatic rx(input bit ir, input logic [7:0] b);
        link.send(ir, b);
        if (ir != ir_on) return;
        if (!fifo_on && rxm.size() == 1) begin
            lost++;
            rxm[0] = b;
        end else if (rxm.size() == USS_DEPTH) lost++;
        else rxm.push_back(b);
    endtask : rx

    task automatic rd_alias(input int idx);
        @(negedge I_SYS_CLK);
        chk_word({31'h0, O_DATA_READY}, {31'h0, rxm.size() != 0}, "data ready");
        @(posedge I_SYS_CLK);
        axi_rd(USS_ALIAS_BASE + 32'(4 * idx), d, r);
        chk_word({30'h0, r}, 32'h0, "alias read resp");
        if (rxm.size() != 0) chk_word(d, {24'h0, rxm.pop_front()}, "rx byte");
    endtask : rd_alias

    task automatic wr_alias(input int idx, input logic [7:0] b);
        axi_wr(USS_ALIAS_BASE + 32'(4 * idx), {24'($urandom()), b}, r);
        chk_word({30'h0, r}, 32'h0, "alias write resp");
        if (!fifo_on && txm.size() == 1) txm[0] = b;
        else if (txm.size() < USS_DEPTH) txm.push_back(b);
    endtask : wr_alias

    task automatic set_ctrl(input logic [1:0] c);
        axi_wr(USS_CTRL_ADDR, {30'h0, c}, r);
        if (c[0] != fifo_on) rxm.delete();
        fifo_on = c[0];
        ir_on   = c[1];
        @(negedge I_SYS_CLK);
        chk_word({30'h0, O_TX_IR_SEL, O_FIFO_EN}, {30'h0, c}, "ctrl outputs");
        @(posedge I_SYS_CLK);
    endtask : set_ctrl

    // release the framer, wait for the transmit side to empty, compare bytes
    task automatic drain_tx();
        int n;
        link.stall = 1'b0;
        for (n = 0; n < 500; n++) begin
            @(negedge I_SYS_CLK);
            if (O_TX_VALID === 1'b0) break;
        end
        if (n == 500) hang();
        chk_word({31'h0, O_HOLDING_EMPTY}, 32'h1, "holding empty after drain");
        @(posedge I_SYS_CLK);
        chk_word(32'(link.tx_got.size()), 32'(txm.size()), "tx count");
        foreach (txm[k]) begin
            if (k < link.tx_got.size()) begin
                chk_word(32'(link.tx_got[k]), 32'(txm[k]), "tx byte");
            end
        end
        txm.delete();
        link.tx_got.delete();
    endtask : drain_tx

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        {I_RST_N, I_AWVALID, I_WVALID, I_ARVALID, I_AWADDR, I_WDATA, I_ARADDR} = '0;
        {I_BREADY, I_RREADY, I_WSTRB} = 6'h3f;
        void'($urandom(32'h64ec3eee));
        repeat (4) @(posedge I_SYS_CLK);
        I_RST_N <= 1'b1;
        @(posedge I_SYS_CLK);
        axi_rd(USS_CTRL_ADDR, d, r);
        chk_word(d, 32'h0, "ctrl reset");
        axi_rd(USS_STAT_ADDR, d, r);
        chk_word(d, 32'h20, "status reset");
        axi_rd(32'h5000_1170, d, r);
        chk_word({30'h0, r}, {30'h0, USS_RESP_SLVERR}, "unmapped resp");
        // single entry: a second unread byte overwrites and flags overrun
        rx(1'b0, 8'($urandom()));
        rx(1'b0, 8'($urandom()));
        axi_rd(USS_STAT_ADDR, d, r);
        chk_word(d, 32'h23, "status after overwrite");
        rd_alias(14);
        chk_word(32'(ovr_seen), 32'(lost), "overrun count");
        // single entry transmit with the framer stalled
        link.stall = 1'b1;
        @(negedge I_SYS_CLK);
        chk_word({31'h0, O_HOLDING_EMPTY}, 32'h1, "holding empty before write");
        @(posedge I_SYS_CLK);
        wr_alias(15, 8'($urandom()));
        @(negedge I_SYS_CLK);
        chk_word({31'h0, O_HOLDING_EMPTY}, 32'h0, "holding empty after write");
        @(posedge I_SYS_CLK);
        wr_alias(0, 8'($urandom()));
        drain_tx();
        // fifo mode: overfill receive, read through all sixteen aliases
        set_ctrl(2'h1);
        repeat (17) rx(1'b0, 8'($urandom()));
        chk_word(32'(ovr_seen), 32'(lost), "overrun count");
        for (i = 0; i < 16; i++) rd_alias(i);
        rd_alias(3);
        link.stall = 1'b1;
        for (i = 0; i < 18; i++) wr_alias(i % 16, 8'($urandom()));
        drain_tx();
        // infrared mode: only the infrared input is taken
        set_ctrl(2'h3);
        rx(1'b1, 8'($urandom()));
        rx(1'b0, 8'($urandom()));
        rd_alias(7);
        rd_alias(8);
        wr_alias(9, 8'($urandom()));
        drain_tx();
        chk_word(32'(ovr_seen), 32'(lost), "overrun count");
        tally_and_finish();
    end
endmodule : uss_top_tb
